// >>> rtl/lars_pkg.sv
// constants and types shared by the linear array readout sequencer
package lars_pkg;

  // pixels held and sent out by one section
  localparam int PIX_PER_SEC  = 384;
  // number of sections on the die
  localparam int SEC_CNT      = 2;
  // width of one held pixel sample
  localparam int PIX_W        = 8;
  // clocks from token capture until the integrator reset ends
  localparam int RESET_CYC    = 18;
  // count value right after the edge that captured the token
  localparam int CNT_FIRST    = 1;
  // flip-flops in each pin synchroniser
  localparam int SYNC_STAGES  = 2;
  // system clock rate
  localparam int SYS_CLK_HZ   = 20_000_000;
  // one system clock period
  localparam int SYS_CLK_NS   = 1_000_000_000 / SYS_CLK_HZ;

  // readout phase of one section
  typedef enum logic [1:0] {
    LARS_IDLE,
    LARS_SWEEP,
    LARS_CARRY
  } lars_phase_e;

endpackage

// >>> rtl/lars_sync.sv
// two-flop synchroniser with a rising-edge pulse taken after the second stage
`timescale 1ns/10ps
module lars_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] lvl_o,
  output logic      [WIDTH-1:0] rise_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } lars_sync_s;

  lars_sync_s st_ff;
  lars_sync_s nxt_st;

  // s1 feeds only s2; the edge detector compares s2 with s3
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lvl_o  = st_ff.s2;
  assign rise_o = st_ff.s2 & ~st_ff.s3;

endmodule // lars_sync

// >>> rtl/lars_top.sv
// two-section linear array readout sequencer: token sweep, freeze, integrator reset
// How it works
// - each section: 384-stage sweep plus reset logic
// - token high at section clock starts sweep
// - freeze rise disconnects capacitors, starts reset
// - freeze copies all pixels into hold buffer
// - reset ends 18 clocks after token capture
// - one held pixel presented per section clock
// - carry out rises on 384th edge
// - 385th edge ends carry, output to high-z
// - cascaded second section carries on 768th edge
// - output high impedance outside output phase
// - each section runs on its own clock
// - sections read separately or cascaded
// - second carry cascades or marks end
`timescale 1ns/10ps
module lars_top #(
  parameter int PIX = lars_pkg::PIX_PER_SEC,
  parameter int W   = lars_pkg::PIX_W
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             section_a_clock_i,
  input  wire logic             section_b_clock_i,
  input  wire logic             start_token_in_a_i,
  input  wire logic             start_token_in_b_i,
  input  wire logic             freeze_strobe_a_i,
  input  wire logic             freeze_strobe_b_i,
  input  wire logic [PIX*W-1:0] integ_level_a_i,
  input  wire logic [PIX*W-1:0] integ_level_b_i,
  output logic      [W-1:0]     pixel_voltage_out_a_o,
  output logic                  pixel_voltage_out_a_oe_n_o,
  output logic      [W-1:0]     pixel_voltage_out_b_o,
  output logic                  pixel_voltage_out_b_oe_n_o,
  output logic      [$clog2(PIX+2)-1:0] pixel_index_a_o,
  output logic      [$clog2(PIX+2)-1:0] pixel_index_b_o,
  output logic                  carry_out_a_o,
  output logic                  carry_out_b_o,
  output logic                  caps_held_a_o,
  output logic                  caps_held_b_o,
  output logic                  integ_reset_a_o,
  output logic                  integ_reset_b_o
);

  localparam int CNT_W = $clog2(PIX+2);
  localparam int NSEC  = lars_pkg::SEC_CNT;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(lars_pkg::CNT_FIRST);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PIX);
  // count reached at the edge that ends the integrator reset
  localparam logic [CNT_W-1:0] CNT_REND = CNT_W'(lars_pkg::CNT_FIRST + lars_pkg::RESET_CYC);

  typedef struct packed {
    lars_pkg::lars_phase_e phase;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      idx;
    logic                  carry;
    logic                  drive_n;
    logic                  hold;
    logic                  integ_rst;
    logic [W-1:0]          pix;
    logic [PIX*W-1:0]      buf_q;
  } lars_sec_s;

  typedef struct packed {
    lars_sec_s [NSEC-1:0] sec;
  } lars_state_s;

  lars_state_s st_ff;
  lars_state_s nxt_st;

  logic                    rst_n;
  logic [3*NSEC-1:0]       pin_lvl;
  logic [3*NSEC-1:0]       pin_rise;
  logic [NSEC-1:0]         clk_rise;
  logic [NSEC-1:0]         tok_lvl;
  logic [NSEC-1:0]         frz_rise;
  logic [NSEC-1:0][PIX*W-1:0] level;

  // reset release through two flops
  lars_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (1'b1),
    .lvl_o  (rst_n),
    .rise_o ()
  );

  // all section pins come from the external controller
  lars_sync #(
    .WIDTH (3*NSEC)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .rstn_i (rst_n),
    .d_i    ({freeze_strobe_b_i, freeze_strobe_a_i,
              start_token_in_b_i, start_token_in_a_i,
              section_b_clock_i, section_a_clock_i}),
    .lvl_o  (pin_lvl),
    .rise_o (pin_rise)
  );

  assign clk_rise = pin_rise[NSEC-1:0];
  assign tok_lvl  = pin_lvl[2*NSEC-1:NSEC];
  assign frz_rise = pin_rise[3*NSEC-1:2*NSEC];
  assign level[0] = integ_level_a_i;
  assign level[1] = integ_level_b_i;

  // one held sample picked by pixel position
  function automatic logic [W-1:0] pick(input logic [PIX*W-1:0] bq,
                                        input logic [CNT_W-1:0] pos);
    pick = bq[int'(pos)*W +: W];
  endfunction

  always_comb begin
    nxt_st = st_ff;
    for (int s = 0; s < NSEC; s++) begin
      // freeze: every sample captured together, integrators reset
      if (frz_rise[s]) begin
        nxt_st.sec[s].hold      = 1'b1;
        nxt_st.sec[s].integ_rst = 1'b1;
        nxt_st.sec[s].buf_q     = level[s];
      end else if (clk_rise[s] && st_ff.sec[s].phase == lars_pkg::LARS_SWEEP &&
                   st_ff.sec[s].cnt == CNT_REND - CNT_ONE) begin
        // integration restarts; capacitors reconnect
        nxt_st.sec[s].hold      = 1'b0;
        nxt_st.sec[s].integ_rst = 1'b0;
      end
      // each section advances only on its own clock
      if (clk_rise[s]) begin
        case (st_ff.sec[s].phase)
          lars_pkg::LARS_IDLE: begin
            if (tok_lvl[s]) begin
              nxt_st.sec[s].phase   = lars_pkg::LARS_SWEEP;
              nxt_st.sec[s].cnt     = CNT_ONE;
              nxt_st.sec[s].idx     = '0;
              nxt_st.sec[s].drive_n = 1'b0;
              nxt_st.sec[s].pix     = pick(nxt_st.sec[s].buf_q, '0);
            end
          end
          lars_pkg::LARS_SWEEP: begin
            nxt_st.sec[s].cnt = st_ff.sec[s].cnt + CNT_ONE;
            nxt_st.sec[s].idx = st_ff.sec[s].cnt;
            nxt_st.sec[s].pix = pick(nxt_st.sec[s].buf_q, st_ff.sec[s].cnt);
            if (st_ff.sec[s].cnt == CNT_LAST - CNT_ONE) begin
              nxt_st.sec[s].phase = lars_pkg::LARS_CARRY;
              nxt_st.sec[s].carry = 1'b1;
            end
          end
          lars_pkg::LARS_CARRY: begin
            nxt_st.sec[s].phase   = lars_pkg::LARS_IDLE;
            nxt_st.sec[s].cnt     = '0;
            nxt_st.sec[s].idx     = '0;
            nxt_st.sec[s].carry   = 1'b0;
            nxt_st.sec[s].drive_n = 1'b1;
            nxt_st.sec[s].pix     = '0;
          end
          default: begin
            nxt_st.sec[s].phase   = lars_pkg::LARS_IDLE;
            nxt_st.sec[s].drive_n = 1'b1;
            nxt_st.sec[s].carry   = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < NSEC; s++) begin
        st_ff.sec[s]         <= '0;
        st_ff.sec[s].phase   <= lars_pkg::LARS_IDLE;
        st_ff.sec[s].drive_n <= 1'b1;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pixel_voltage_out_a_o      = st_ff.sec[0].pix;
  assign pixel_voltage_out_b_o      = st_ff.sec[1].pix;
  assign pixel_voltage_out_a_oe_n_o = st_ff.sec[0].drive_n;
  assign pixel_voltage_out_b_oe_n_o = st_ff.sec[1].drive_n;
  assign pixel_index_a_o            = st_ff.sec[0].idx;
  assign pixel_index_b_o            = st_ff.sec[1].idx;
  assign carry_out_a_o              = st_ff.sec[0].carry;
  assign carry_out_b_o              = st_ff.sec[1].carry;
  assign caps_held_a_o              = st_ff.sec[0].hold;
  assign caps_held_b_o              = st_ff.sec[1].hold;
  assign integ_reset_a_o            = st_ff.sec[0].integ_rst;
  assign integ_reset_b_o            = st_ff.sec[1].integ_rst;

  // per-section checks
  for (genvar g = 0; g < NSEC; g++) begin : g_chk
    logic [CNT_W-1:0] edges_ff;

    // counts section edges since the token was taken
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        edges_ff <= '0;
      end else if (clk_rise[g]) begin
        if (st_ff.sec[g].phase == lars_pkg::LARS_IDLE && tok_lvl[g]) begin
          edges_ff <= CNT_ONE;
        end else if (st_ff.sec[g].phase != lars_pkg::LARS_IDLE) begin
          edges_ff <= edges_ff + CNT_ONE;
        end
      end
    end

    property p_start;
      @(posedge clk_i) disable iff (!rst_n)
      clk_rise[g] && tok_lvl[g] && st_ff.sec[g].phase == lars_pkg::LARS_IDLE
      |=> st_ff.sec[g].phase == lars_pkg::LARS_SWEEP && st_ff.sec[g].cnt == CNT_ONE
          && !st_ff.sec[g].drive_n && st_ff.sec[g].idx == '0;
    endproperty
    a_start: assert property (p_start)
      else $error("sweep did not start on token");

    property p_carry_edge;
      @(posedge clk_i) disable iff (!rst_n)
      $rose(st_ff.sec[g].carry) |-> edges_ff == CNT_LAST && $past(clk_rise[g]);
    endproperty
    a_carry_edge: assert property (p_carry_edge)
      else $error("carry rose on wrong section edge");

    property p_carry_end;
      @(posedge clk_i) disable iff (!rst_n)
      st_ff.sec[g].carry && clk_rise[g]
      |=> !st_ff.sec[g].carry && st_ff.sec[g].drive_n
          && st_ff.sec[g].phase == lars_pkg::LARS_IDLE;
    endproperty
    a_carry_end: assert property (p_carry_end)
      else $error("carry not ended by next section edge");

    property p_hiz_idle;
      @(posedge clk_i) disable iff (!rst_n)
      st_ff.sec[g].phase == lars_pkg::LARS_IDLE |-> st_ff.sec[g].drive_n
                                                    && !st_ff.sec[g].carry;
    endproperty
    a_hiz_idle: assert property (p_hiz_idle)
      else $error("output driven outside output phase");

    property p_freeze;
      @(posedge clk_i) disable iff (!rst_n)
      frz_rise[g] |=> st_ff.sec[g].hold && st_ff.sec[g].integ_rst
                      && st_ff.sec[g].buf_q == $past(level[g]);
    endproperty
    a_freeze: assert property (p_freeze)
      else $error("freeze did not hold samples and reset integrators");

    property p_reset_end;
      @(posedge clk_i) disable iff (!rst_n)
      $fell(st_ff.sec[g].integ_rst) |-> edges_ff == CNT_REND && !st_ff.sec[g].hold;
    endproperty
    a_reset_end: assert property (p_reset_end)
      else $error("integrator reset ended at wrong count");

    property p_pix_seq;
      @(posedge clk_i) disable iff (!rst_n)
      clk_rise[g] && st_ff.sec[g].phase == lars_pkg::LARS_SWEEP
      |=> st_ff.sec[g].idx == $past(st_ff.sec[g].idx) + CNT_ONE
          && st_ff.sec[g].pix == pick(st_ff.sec[g].buf_q, st_ff.sec[g].idx);
    endproperty
    a_pix_seq: assert property (p_pix_seq)
      else $error("pixel sequence skipped or wrong sample");

    property p_own_clock;
      @(posedge clk_i) disable iff (!rst_n)
      !clk_rise[g] |=> $stable(st_ff.sec[g].cnt) && $stable(st_ff.sec[g].phase);
    endproperty
    a_own_clock: assert property (p_own_clock)
      else $error("section moved without its own clock");

    property p_sweep_len;
      @(posedge clk_i) disable iff (!rst_n)
      st_ff.sec[g].phase != lars_pkg::LARS_IDLE |-> edges_ff <= CNT_LAST
                                                    && edges_ff == st_ff.sec[g].cnt;
    endproperty
    a_sweep_len: assert property (p_sweep_len)
      else $error("sweep count out of step");

    property p_out_stand;
      @(posedge clk_i) disable iff (!rst_n)
      !clk_rise[g] |=> $stable(st_ff.sec[g].pix) && $stable(st_ff.sec[g].idx)
                       && $stable(st_ff.sec[g].carry) && $stable(st_ff.sec[g].drive_n);
    endproperty
    a_out_stand: assert property (p_out_stand)
      else $error("output changed between section edges");

    property p_last_pixel;
      @(posedge clk_i) disable iff (!rst_n)
      $rose(st_ff.sec[g].carry) |-> st_ff.sec[g].idx == CNT_LAST - CNT_ONE
                                    && st_ff.sec[g].phase == lars_pkg::LARS_CARRY;
    endproperty
    a_last_pixel: assert property (p_last_pixel)
      else $error("carry not on last pixel of section");
  end

endmodule // lars_top

// >>> test/lars_ctrl_model.sv
// controller model: section clocks, start tokens and freeze strobes
`timescale 1ns/10ps
module lars_ctrl_model (
  input  wire logic clk_i,
  input  wire logic carry_a_i,
  output logic      sec_clk_a_o,
  output logic      sec_clk_b_o,
  output logic      tok_a_o,
  output logic      tok_b_o,
  output logic      frz_a_o,
  output logic      frz_b_o
);
  logic ser;
  logic tok_a_r;
  logic tok_b_r;

  initial begin
    ser = 1'b0;
    tok_a_r = 1'b0;
    tok_b_r = 1'b0;
    sec_clk_a_o = 1'b0;
    sec_clk_b_o = 1'b0;
  end

  assign tok_a_o = tok_a_r;
  assign frz_a_o = tok_a_r;
  assign tok_b_o = ser ? carry_a_i : tok_b_r;
  assign frz_b_o = ser ? tok_a_r : tok_b_r;

  // token one cycle ahead of the first rise, then n clocks of 3 high and 3 low
  task automatic sweep(input int serial, input int sec_b, input int n);
    @(posedge clk_i);
    ser <= 1'(serial);
    if (sec_b != 0 && serial == 0) tok_b_r <= 1'b1;
    else tok_a_r <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (serial != 0 || sec_b == 0) sec_clk_a_o <= 1'b1;
      if (serial != 0 || sec_b != 0) sec_clk_b_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sec_clk_a_o <= 1'b0;
      sec_clk_b_o <= 1'b0;
      tok_a_r <= 1'b0;
      tok_b_r <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
endmodule // lars_ctrl_model

// >>> test/lars_top_tb_top.sv
// testbench: a separate sweep of each section in turn and a cascaded sweep
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module lars_top_tb_top;
  localparam int P = lars_pkg::PIX_PER_SEC;
  localparam int W = lars_pkg::PIX_W;
  localparam int R = lars_pkg::RESET_CYC + 1;

  logic              clk_i;
  logic              rstn;
  logic [P*W-1:0]    lvl [2];
  wire  [1:0][W-1:0] pix;
  wire  [1:0][8:0]   idx;
  wire  [1:0]        oe_n;
  wire  [1:0]        car;
  wire  [1:0]        irst;
  wire  [1:0]        held;
  wire  [1:0]        sclk;
  wire  [1:0]        tok;
  wire  [1:0]        frz;
  int                n_errors = 0;
  int                n_tests = 0;
  logic [W-1:0]      salt;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  lars_ctrl_model ctl (
    .clk_i(clk_i), .carry_a_i(car[0]), .sec_clk_a_o(sclk[0]), .sec_clk_b_o(sclk[1]),
    .tok_a_o(tok[0]), .tok_b_o(tok[1]), .frz_a_o(frz[0]), .frz_b_o(frz[1])
  );

  lars_top dut (
    .clk_i(clk_i), .rstn_i(rstn),
    .section_a_clock_i(sclk[0]), .section_b_clock_i(sclk[1]),
    .start_token_in_a_i(tok[0]), .start_token_in_b_i(tok[1]),
    .freeze_strobe_a_i(frz[0]), .freeze_strobe_b_i(frz[1]),
    .integ_level_a_i(lvl[0]), .integ_level_b_i(lvl[1]),
    .pixel_voltage_out_a_o(pix[0]), .pixel_voltage_out_a_oe_n_o(oe_n[0]),
    .pixel_voltage_out_b_o(pix[1]), .pixel_voltage_out_b_oe_n_o(oe_n[1]),
    .pixel_index_a_o(idx[0]), .pixel_index_b_o(idx[1]),
    .carry_out_a_o(car[0]), .carry_out_b_o(car[1]),
    .caps_held_a_o(held[0]), .caps_held_b_o(held[1]),
    .integ_reset_a_o(irst[0]), .integ_reset_b_o(irst[1])
  );

  function automatic logic [W-1:0] pat(input int s, input int k);
    return 8'(k) ^ ((s != 0) ? 8'ha5 : 8'h3c) ^ salt;
  endfunction

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic fill();
    @(posedge clk_i);
    for (int k = 0; k < P; k++) begin
      lvl[0][k*W +: W] <= pat(0, k);
      lvl[1][k*W +: W] <= pat(1, k);
    end
  endtask

  // n is the section's own clock count since capture; below 1 means armed, not yet started
  task automatic edge_chk(input int s, input int n);
    logic act;
    act = (n >= 1) && (n <= P);
    `CHK("oe_n", oe_n[s], !act)
    `CHK("index", idx[s], 9'(act ? n - 1 : 0))
    `CHK("pixel", pix[s], (act ? pat(s, n - 1) : 8'h00))
    `CHK("carry", car[s], 1'(n == P))
    `CHK("integ_reset", irst[s], 1'(n < R))
    `CHK("caps_held", held[s], 1'(n < R))
  endtask

  // sample each section clock rise 5 system cycles later, once the sync latency has passed
  task automatic sweep_check(input int ser, input int sb, input int total);
    fill();
    fork
      ctl.sweep(ser, sb, total);
      for (int i = 1; i <= total; i++) begin
        @(posedge sclk[sb]);
        repeat (5) @(posedge clk_i);
        if (i == 2) begin
          lvl[0] <= ~lvl[0];
          lvl[1] <= ~lvl[1];
        end
        #1;
        if (ser != 0) begin
          edge_chk(0, i);
          edge_chk(1, i - P);
        end else begin
          edge_chk(sb, i);
          `CHK("oe_n idle", oe_n[1 - sb], 1'b1)
        end
      end
    join
  endtask

  task automatic scn_section_a();
    sweep_check(0, 0, P + 1);
  endtask

  task automatic scn_section_b();
    sweep_check(0, 1, P + 1);
  endtask

  task automatic scn_cascade();
    // new pattern: both buffers must take a fresh snapshot
    salt = 8'h5a;
    sweep_check(1, 0, 2 * P + 1);
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    close_out();
  end

  initial begin
    rstn = 1'b0;
    lvl[0] = '0;
    lvl[1] = '0;
    salt = 8'h00;
    repeat (8) @(posedge clk_i);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("oe_n reset", oe_n, 2'b11)
    `CHK("carry reset", car, 2'b00)
    scn_section_a();
    scn_section_b();
    scn_cascade();
    close_out();
  end
endmodule // lars_top_tb_top
